// >>> logic/spool_actuator_defs.svh
/*
 Constants for the spool actuator fault monitor: setpoint window, tracking
 margins, delays and pin indices. Assumes a 100 MHz clock and ratiometric
 setpoint codes in per-mille of supply.
*/
`ifndef SPOOL_ACTUATOR_DEFS_SVH
`define SPOOL_ACTUATOR_DEFS_SVH
`define CLK_MHZ         100
`define CYC_PER_MS      (`CLK_MHZ * 1000)
`define SP_MIN          10'h096
`define SP_MAX          10'h352
`define SP_MID          12'h1f4
`define SP_SPAN         350
`define TRACK_PCT_STD   12
`define TRACK_PCT_RED   25
`define T_ACT_MS        500
`define T_PAS_MS        250
`define T_RED_MS        750
`define T_HOLD_MS       100
`define T_FLOAT_IN_MS   500
`define T_FLOAT_OUT_MS  750
`define INIT_CYC        5'h10
`define NEUTRAL_TOL_UM  500
`define DI_ON_UM        800
`define DI_OFF_UM       400
`define CL_DEADBAND     12'h002
`define PIN_N           11
`define PIN_FLOAT_SP    0
`define PIN_SPOOL_POSITION_TRANSDUCER_OPEN   1
`define PIN_SPOOL_POSITION_TRANSDUCER_SHORT  2
`define PIN_FLOAT_CMD   3
`define PIN_FLOAT_ACT   4
`define PIN_SUPPLY_BAD  5
`define PIN_CLK_BAD     6
`define PIN_REDUCED     7
`define PIN_SIX_PIN     8
`define PIN_PASSIVE     9
`define PIN_DI          10
`endif

// >>> logic/spool_actuator_pkg.sv
/*
 Types for the spool actuator fault monitor.
 Assumes the defs header is compiled alongside.
*/
package spool_actuator_pkg;
    typedef struct packed {
        logic nc1;
        logic no2;
        logic nc3;
        logic no4;
    } sol_t;
    typedef struct packed {
        logic range_bad;
        logic wire_bad;
        logic track_bad;
        logic float_bad;
    } err_src_t;
    typedef struct packed {
        logic reduced_bridge_variant;
        logic six_pin_float_variant;
        logic passive_mode;
        logic direction_indication_outputs;
    } strap_t;
    typedef enum logic [1:0] {
        ST_INIT,
        ST_RUN,
        ST_FAULT_ACT,
        ST_FAULT_PAS
    } mon_state_t;
endpackage : spool_actuator_pkg

// >>> logic/spool_actuator_fault_monitor.sv
/*
 Closed-loop spool positioning and fault supervision of a valve actuator.
 Assumes setpoint and position codes come from ADC logic on mclk; all other
 status pins and variant straps are asynchronous and are synchronised here.
*/
// How it works
// - Setpoint outside 15..85% of supply is error
// - Floating setpoint input means neutral demand
// - Open or shorted transducer wiring is error
// - Overshoot beyond 12%/25%, or opposite, errors
// - Neutral demand allows 0.5 mm deviation only
// - Nearer neutral, same direction is in control
// - Six-pin variant times float entry and exit
// - Active reaction after 500 ms, 750 reduced
// - Active reaction disables whole solenoid bridge
// - Active reaction latched until power cycle
// - Passive reaction after 250 ms, 750 reduced
// - Passive reaction keeps bridge driving spool
// - Passive indication holds 100 ms, self-clears
// - Any reaction raises error pin, red LED
// - Direction outputs both low during reaction
// - All solenoids closed at power-up first
// - Drive solenoids from setpoint minus position
// - Both modes share the four error sources
// - Supply or clock fault disables solenoids
`timescale 1ns/100ps
`default_nettype none
`include "spool_actuator_defs.svh"
module spool_actuator_fault_monitor
    import spool_actuator_pkg::*;
#(
    parameter int unsigned CNT_W         = 27,
    parameter int unsigned POS_W         = 12,
    parameter int unsigned COUNTS_PER_MM = 50,
    parameter int unsigned ACT_DLY_CYC   = `T_ACT_MS * `CYC_PER_MS,
    parameter int unsigned PAS_DLY_CYC   = `T_PAS_MS * `CYC_PER_MS,
    parameter int unsigned RED_DLY_CYC   = `T_RED_MS * `CYC_PER_MS,
    parameter int unsigned HOLD_CYC      = `T_HOLD_MS * `CYC_PER_MS,
    parameter int unsigned FLT_IN_CYC    = `T_FLOAT_IN_MS * `CYC_PER_MS,
    parameter int unsigned FLT_OUT_CYC   = `T_FLOAT_OUT_MS * `CYC_PER_MS
)(
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic [9:0]              setpoint_voltage,
    input  wire logic signed [POS_W-1:0] spool_pos,
    input  wire logic                    setpoint_floating,
    input  wire logic                    spool_position_transducer_open,
    input  wire logic                    spool_position_transducer_short,
    input  wire logic                    float_cmd,
    input  wire logic                    float_active,
    input  wire logic                    supply_out_of_range,
    input  wire logic                    clock_fail,
    input  wire logic                    strap_reduced_bridge,
    input  wire logic                    strap_six_pin_float,
    input  wire logic                    strap_passive_mode,
    input  wire logic                    strap_direction_outputs,
    output sol_t                         sol_open_r,
    output logic                         bridge_enable_r,
    output logic                         error_pin_r,
    output logic                         led_red_r,
    output logic                         led_flash_r,
    output logic                         di_a_r,
    output logic                         di_b_r,
    output err_src_t                     err_src_r
);
    localparam int unsigned DL_W = POS_W + 1;
    localparam logic [POS_W-1:0] TRK_STD =
        POS_W'(`SP_SPAN * `TRACK_PCT_STD / 100);
    localparam logic [POS_W-1:0] TRK_RED =
        POS_W'(`SP_SPAN * `TRACK_PCT_RED / 100);
    localparam logic [POS_W-1:0] NTOL =
        POS_W'(`NEUTRAL_TOL_UM * COUNTS_PER_MM / 1000);
    localparam logic [POS_W-1:0] DI_ON =
        POS_W'(`DI_ON_UM * COUNTS_PER_MM / 1000);
    localparam logic [POS_W-1:0] DI_OFF =
        POS_W'(`DI_OFF_UM * COUNTS_PER_MM / 1000);

    // Refuse widths and delays the counters cannot hold
    generate
        if (CNT_W > 32 || POS_W < 11 || POS_W > 16 ||
            ACT_DLY_CYC >= (64'h1 << CNT_W) || PAS_DLY_CYC >= (64'h1 << CNT_W) ||
            RED_DLY_CYC >= (64'h1 << CNT_W) || HOLD_CYC >= (64'h1 << CNT_W) ||
            FLT_IN_CYC >= (64'h1 << CNT_W) || FLT_OUT_CYC >= (64'h1 << CNT_W) ||
            ACT_DLY_CYC == 0 || PAS_DLY_CYC == 0 || RED_DLY_CYC == 0 ||
            HOLD_CYC == 0 || FLT_IN_CYC == 0 || FLT_OUT_CYC == 0)
        begin : g_bad_params
            $error("spool_actuator_fault_monitor: unsupported parameters");
        end
    endgenerate

    // Magnitude of a two's complement code
    function automatic logic [POS_W-1:0] mag(input logic signed [POS_W-1:0] v);
        mag = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
    endfunction : mag

    // Pin synchroniser; first stage feeds only the second
    logic [`PIN_N-1:0] pin_meta_r;
    logic [`PIN_N-1:0] pin_sync_r;
    wire  [`PIN_N-1:0] pins_raw = {strap_direction_outputs, strap_passive_mode,
                                   strap_six_pin_float, strap_reduced_bridge,
                                   clock_fail, supply_out_of_range, float_active,
                                   float_cmd, spool_position_transducer_short, spool_position_transducer_open,
                                   setpoint_floating};

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else if (ce)
        begin
            pin_meta_r <= pins_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    mon_state_t             state_r;
    mon_state_t             state_nxt;
    strap_t                 strap_r;
    logic [4:0]             init_r;
    logic [CNT_W-1:0]       qual_r;
    logic [CNT_W-1:0]       hold_r;
    logic [CNT_W-1:0]       flt_r;

    // Setpoint decoding
    wire sp_float  = pin_sync_r[`PIN_FLOAT_SP];
    wire range_bad = !sp_float &&
                     (setpoint_voltage < `SP_MIN || setpoint_voltage > `SP_MAX);
    // Mid code maps to a neutral demand
    wire signed [POS_W-1:0] dem_raw =
        $signed(POS_W'(setpoint_voltage)) - $signed(POS_W'(`SP_MID));
    wire signed [POS_W-1:0] dem = sp_float ? '0 : dem_raw;
    wire [POS_W-1:0] dem_mag = mag(dem);
    wire [POS_W-1:0] pos_mag = mag(spool_pos);
    wire dem_neutral = (dem == '0);

    // Transducer wiring
    wire wire_bad = pin_sync_r[`PIN_SPOOL_POSITION_TRANSDUCER_OPEN] || pin_sync_r[`PIN_SPOOL_POSITION_TRANSDUCER_SHORT];

    // Spool tracking; nearer neutral on the same side is accepted
    wire [POS_W-1:0] trk_tol = strap_r.reduced_bridge_variant ? TRK_RED : TRK_STD;
    wire [DL_W-1:0]  trk_lim = {1'b0, dem_mag} + {1'b0, trk_tol};
    wire over_out  = {1'b0, pos_mag} > trk_lim;
    wire opposite  = (spool_pos[POS_W-1] != dem[POS_W-1]) && (pos_mag > NTOL);
    wire neut_bad  = pos_mag > NTOL;
    wire track_bad = dem_neutral ? neut_bad : (over_out || opposite);

    // Float timing, six-pin variant only
    wire flt_cmd   = pin_sync_r[`PIN_FLOAT_CMD];
    wire flt_act   = pin_sync_r[`PIN_FLOAT_ACT];
    wire flt_wait  = strap_r.six_pin_float_variant && (flt_cmd != flt_act);
    wire [CNT_W-1:0] flt_lim = flt_cmd ? CNT_W'(FLT_IN_CYC) : CNT_W'(FLT_OUT_CYC);
    wire float_bad = flt_wait && (flt_r >= flt_lim);

    // Same sources feed either monitoring mode
    wire monitoring = (state_r != ST_INIT);
    err_src_t err_now;
    assign err_now = '{range_bad: range_bad && monitoring,
                       wire_bad:  wire_bad && monitoring,
                       track_bad: track_bad && monitoring,
                       float_bad: float_bad && monitoring};
    wire err_any = |err_now;

    // Qualification delay by mode and variant
    wire [CNT_W-1:0] dly_sel =
        strap_r.reduced_bridge_variant ? CNT_W'(RED_DLY_CYC) :
        strap_r.passive_mode           ? CNT_W'(PAS_DLY_CYC) :
                                         CNT_W'(ACT_DLY_CYC);
    // One less: state flips on the edge that completes the count
    wire qual_done = err_any && (qual_r >= dly_sel - CNT_W'(1));
    wire hold_done = (hold_r >= CNT_W'(HOLD_CYC) - CNT_W'(1));
    wire init_done = (init_r == `INIT_CYC);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_INIT:
                if (init_done)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (qual_done)
                    state_nxt = strap_r.passive_mode ? ST_FAULT_PAS : ST_FAULT_ACT;
            ST_FAULT_ACT:
                state_nxt = ST_FAULT_ACT;
            ST_FAULT_PAS:
                if (hold_done && !err_any)
                    state_nxt = ST_RUN;
            default:
                state_nxt = ST_INIT;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_r <= ST_INIT;
            init_r  <= '0;
            strap_r <= '0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            // Init count stops at its end and never wraps
            if (!init_done)
                init_r <= init_r + 5'h01;
            // Straps caught once, after the synchroniser has settled
            if (state_r == ST_INIT && init_done)
                strap_r <= '{reduced_bridge_variant:       pin_sync_r[`PIN_REDUCED],
                             six_pin_float_variant:        pin_sync_r[`PIN_SIX_PIN],
                             passive_mode:                 pin_sync_r[`PIN_PASSIVE],
                             direction_indication_outputs: pin_sync_r[`PIN_DI]};
        end
    end

    // Timers; qualify count drops to zero on any clean cycle
    // Hold and float counts stop at their ends, so neither wraps
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            qual_r <= '0;
            hold_r <= '0;
            flt_r  <= '0;
        end
        else if (ce)
        begin
            if (!err_any || state_r != ST_RUN)
                qual_r <= '0;
            else
                qual_r <= qual_r + CNT_W'(1);
            if (state_r != ST_FAULT_PAS)
                hold_r <= '0;
            else if (!hold_done)
                hold_r <= hold_r + CNT_W'(1);
            if (!flt_wait)
                flt_r <= '0;
            else if (!float_bad)
                flt_r <= flt_r + CNT_W'(1);
        end
    end

    // Bridge drive
    wire in_react   = (state_r == ST_FAULT_ACT) || (state_r == ST_FAULT_PAS);
    // Supply or clock trouble cuts drive but raises no reaction
    wire power_bad  = pin_sync_r[`PIN_SUPPLY_BAD] || pin_sync_r[`PIN_CLK_BAD];
    wire drive_ok   = (state_r == ST_RUN || state_r == ST_FAULT_PAS) && !power_bad;
    wire signed [POS_W-1:0] pos_err = dem - spool_pos;
    wire move_pos   = !pos_err[POS_W-1] && (pos_err > $signed(`CL_DEADBAND));
    wire move_neg   = pos_err[POS_W-1] && (mag(pos_err) > `CL_DEADBAND);
    // Reduced bridge has orifices in the NO positions no2 and no4, so those stay off
    wire red        = strap_r.reduced_bridge_variant;
    sol_t sol_nxt;
    assign sol_nxt = !drive_ok ? '0 :
                     move_pos ? '{nc1: 1'b1, no2: 1'b0, nc3: 1'b0, no4: !red} :
                     move_neg ? '{nc1: 1'b0, no2: !red, nc3: 1'b1, no4: 1'b0} :
                                '0;

    // Direction indication with hysteresis
    // Band between the thresholds keeps the outputs from chattering
    wire a_low_nxt = spool_pos[POS_W-1] ? 1'b0 :
                     (pos_mag > DI_ON) ? 1'b1 : (pos_mag < DI_OFF) ? 1'b0 : !di_a_r;
    wire b_low_nxt = !spool_pos[POS_W-1] ? 1'b0 :
                     (pos_mag > DI_ON) ? 1'b1 : (pos_mag < DI_OFF) ? 1'b0 : !di_b_r;
    wire di_on     = strap_r.direction_indication_outputs && monitoring && !in_react;

    // Constant red marks a transducer cause, flashing the others
    err_src_t cause_nxt;
    assign cause_nxt = (state_r == ST_RUN && qual_done) ? err_now :
                       in_react ? err_src_r : '0;

    // Reset leaves every valve closed and all indications off

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sol_open_r      <= '0;
            bridge_enable_r <= 1'b0;
            error_pin_r     <= 1'b0;
            led_red_r       <= 1'b0;
            led_flash_r     <= 1'b0;
            di_a_r          <= 1'b0;
            di_b_r          <= 1'b0;
            err_src_r       <= '0;
        end
        else if (ce)
        begin
            sol_open_r      <= sol_nxt;
            bridge_enable_r <= drive_ok;
            error_pin_r     <= in_react;
            led_red_r       <= in_react;
            led_flash_r     <= in_react && !err_src_r.wire_bad;
            di_a_r          <= di_on && !a_low_nxt;
            di_b_r          <= di_on && !b_low_nxt;
            err_src_r       <= cause_nxt;
        end
    end

endmodule : spool_actuator_fault_monitor
`default_nettype wire

// >>> verif/spool_monitor_sva.sv
/*
 Checker for the spool actuator fault monitor ports.
 Assumes ce held high and straps changed only while rst_n is low.
*/
`timescale 1ns/100ps
`default_nettype none
module spool_monitor_sva
    import spool_actuator_pkg::*;
(
    input wire logic     mclk,
    input wire logic     rst_n,
    input wire logic     supply_out_of_range,
    input wire logic     strap_passive_mode,
    input wire sol_t     sol_open_r,
    input wire logic     bridge_enable_r,
    input wire logic     error_pin_r,
    input wire logic     led_red_r,
    input wire logic     di_a_r,
    input wire logic     di_b_r,
    input wire err_src_t err_src_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_init_closed: assert property ($rose(rst_n) |-> (sol_open_r == 4'h0) [*8])
        else $error("solenoid opened during init");
    a_act_off: assert property (error_pin_r && !strap_passive_mode |->
        sol_open_r == 4'h0 && !bridge_enable_r) else $error("bridge live in active fault");
    a_act_latch: assert property (error_pin_r && !strap_passive_mode |=> error_pin_r)
        else $error("active fault released");
    a_pas_hold: assert property ($rose(error_pin_r) && strap_passive_mode |-> error_pin_r [*8])
        else $error("passive fault too short");
    // Supply lag of the synchroniser excluded by four clean cycles
    a_pas_drive: assert property ((error_pin_r && strap_passive_mode && !supply_out_of_range) [*4]
        |-> bridge_enable_r) else $error("bridge off in passive fault");
    a_led_follow: assert property (error_pin_r |-> led_red_r)
        else $error("led not red in fault");
    a_di_low: assert property (error_pin_r |-> !di_a_r && !di_b_r)
        else $error("direction output high in fault");
    a_err_cause: assert property ($rose(error_pin_r) |-> err_src_r != 4'h0)
        else $error("fault without cause");
    a_supply_cut: assert property (supply_out_of_range [*4] |-> sol_open_r == 4'h0)
        else $error("solenoid open on bad supply");
endmodule : spool_monitor_sva
bind spool_actuator_fault_monitor spool_monitor_sva chk_i (.mclk, .rst_n, .supply_out_of_range,
    .strap_passive_mode, .sol_open_r, .bridge_enable_r, .error_pin_r, .led_red_r, .di_a_r,
    .di_b_r, .err_src_r);
`default_nettype wire

// >>> verif/setpoint_source.sv
/*
 External controller model: proportional setpoint code or a floating pin.
 Assumes the bench drives demand and float_req on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module setpoint_source
(
    input  wire logic       mclk,
    input  wire logic [9:0] demand,
    input  wire logic       float_req,
    output logic [9:0]      setpoint_voltage = 10'h1f4,
    output logic            setpoint_floating = 1'b0
);
    always_ff @(posedge mclk)
    begin
        setpoint_floating <= float_req;
        // Released pin shows no stale code; voltage form only, no PWM
        setpoint_voltage <= float_req ? ~setpoint_voltage : demand;
    end
endmodule : setpoint_source
`default_nettype wire

// >>> verif/spool_actuator_fault_monitor_tb_top.sv
/*
 Self-checking bench for the spool actuator fault monitor.
 Assumes shortened delays: active 50, passive 25, reduced 75, hold 10.
*/
`timescale 1ns/100ps
`default_nettype none
module spool_actuator_fault_monitor_tb_top;
    import spool_actuator_pkg::*;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              float_req = 1'b0;
    logic              spool_position_transducer_short = 1'b0;
    logic              spool_position_transducer_open = 1'b0;
    logic              float_cmd = 1'b0;
    logic              float_active = 1'b0;
    logic              clock_fail = 1'b0;
    logic              supply_bad = 1'b0;
    logic [3:0]        straps = 4'h0;
    logic [9:0]        demand = 10'h1f4;
    logic signed [11:0] spool_pos = 12'sh000;
    wire logic [9:0]   sp_code;
    wire logic         sp_float;
    sol_t              sol;
    err_src_t          src;
    logic              bridge, err_pin, led_red, led_flash, di_a, di_b;
    int                err_total = 0;
    int                comparisons = 0;
    always #5 mclk = ~mclk;
    setpoint_source ctrl_i (.mclk(mclk), .demand(demand), .float_req(float_req),
        .setpoint_voltage(sp_code), .setpoint_floating(sp_float));
    spool_actuator_fault_monitor #(.ACT_DLY_CYC(50), .PAS_DLY_CYC(25), .RED_DLY_CYC(75),
        .HOLD_CYC(10), .FLT_IN_CYC(50), .FLT_OUT_CYC(75)) uut (
        .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .setpoint_voltage(sp_code),
        .spool_pos(spool_pos), .setpoint_floating(sp_float), .spool_position_transducer_open(spool_position_transducer_open),
        .spool_position_transducer_short(spool_position_transducer_short), .float_cmd(float_cmd), .float_active(float_active),
        .supply_out_of_range(supply_bad), .clock_fail(clock_fail),
        .strap_reduced_bridge(straps[3]), .strap_six_pin_float(straps[2]),
        .strap_passive_mode(straps[1]), .strap_direction_outputs(straps[0]),
        .sol_open_r(sol), .bridge_enable_r(bridge), .error_pin_r(err_pin),
        .led_red_r(led_red), .led_flash_r(led_flash), .di_a_r(di_a),
        .di_b_r(di_b), .err_src_r(src));
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic boot(input logic [3:0] s);
        @(posedge mclk);
        rst_n <= 1'b0;
        straps <= s;
        demand <= 10'h1f4;
        spool_pos <= 12'sh000;
        spool_position_transducer_short <= 1'b0;
        spool_position_transducer_open <= 1'b0;
        float_cmd <= 1'b0;
        float_active <= 1'b0;
        clock_fail <= 1'b0;
        supply_bad <= 1'b0;
        float_req <= 1'b0;
        cyc(4);
        rst_n <= 1'b1;
    endtask : boot
    task automatic test_powerup;
        boot(4'h0);
        demand <= 10'h258;
        cyc(10);
        @(negedge mclk) chk(8'h00, {4'h0, sol});
        cyc(13);
        @(negedge mclk) chk(8'h09, {4'h0, sol});
        cyc(1);
        demand <= 10'h190;
        cyc(60);
        @(negedge mclk) chk(8'h06, {4'h0, sol});
        chk(8'h00, {7'h0, err_pin});
        cyc(1);
        supply_bad <= 1'b1;
        cyc(6);
        @(negedge mclk) chk(8'h00, {4'h0, sol});
        cyc(1);
        supply_bad <= 1'b0;
        clock_fail <= 1'b1;
        cyc(6);
        @(negedge mclk) chk(8'h00, {3'h0, bridge, sol});
        cyc(1);
        clock_fail <= 1'b0;
        $display("test powerup done");
    endtask : test_powerup
    task automatic test_active(input logic red);
        int dly;
        dly = red ? 75 : 50;
        boot({red, 3'b000});
        cyc(20);
        demand <= 10'h064;
        cyc(dly - 10);
        demand <= 10'h1f4;
        cyc(3);
        demand <= 10'h064;
        cyc(dly - 5);
        @(negedge mclk) chk(8'h00, {7'h0, err_pin});
        cyc(12);
        @(negedge mclk) chk(8'h03, {6'h0, err_pin, led_red});
        chk(8'h00, {3'h0, bridge, sol});
        chk(8'h08, {4'h0, src});
        cyc(1);
        demand <= 10'h1f4;
        cyc(20);
        @(negedge mclk) chk(8'h01, {7'h0, err_pin});
        $display("test active done");
    endtask : test_active
    task automatic test_passive;
        boot(4'h3);
        cyc(25);
        @(negedge mclk) chk(8'h03, {6'h0, di_a, di_b});
        cyc(1);
        spool_pos <= 12'sh01e;
        cyc(20);
        @(negedge mclk) chk(8'h00, {7'h0, err_pin});
        cyc(12);
        @(negedge mclk) chk(8'h05, {5'h0, err_pin, di_a, bridge});
        chk(8'h02, {4'h0, src});
        cyc(1);
        spool_pos <= 12'sh000;
        cyc(20);
        @(negedge mclk) chk(8'h00, {7'h0, err_pin});
        $display("test passive done");
    endtask : test_passive
    task automatic test_sources;
        int i;
        boot(4'h0);
        // Last code out of range, so a missed float shows either way
        demand <= 10'h064;
        cyc(1);
        float_req <= 1'b1;
        cyc(90);
        @(negedge mclk) chk(8'h00, {3'h0, err_pin, sol});
        cyc(1);
        float_req <= 1'b0;
        demand <= 10'h258;
        spool_pos <= 12'sh0a0;
        cyc(70);
        @(negedge mclk) chk(8'h12, {3'h0, err_pin, src});
        for (i = 0; i < 2; i++)
        begin
            boot(4'h0);
            spool_position_transducer_open <= i[0];
            spool_position_transducer_short <= !i[0];
            cyc(90);
            @(negedge mclk) chk(8'h14, {3'h0, err_pin, src});
            chk(8'h00, {7'h0, led_flash});
        end
        $display("test sources done");
    endtask : test_sources
    task automatic test_float(input logic cmd);
        int lim;
        lim = cmd ? 50 : 75;
        boot(4'h4);
        cyc(20);
        float_cmd <= cmd;
        float_active <= !cmd;
        cyc(lim + 30);
        @(negedge mclk) chk(8'h00, {7'h0, err_pin});
        cyc(40);
        @(negedge mclk) chk(8'h11, {3'h0, err_pin, src});
        chk(8'h01, {7'h0, led_flash});
        $display("test float done");
    endtask : test_float
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        test_powerup();
        test_active(1'b0);
        test_active(1'b1);
        test_passive();
        test_sources();
        test_float(1'b1);
        test_float(1'b0);
        test_done();
    end
    // Whole run needs about 1200 cycles
    initial
    begin
        cyc(3000);
        err_total++;
        test_done();
    end
endmodule : spool_actuator_fault_monitor_tb_top
`default_nettype wire
